// ### inc/fpio_ifs.sv
`timescale 1ns/100ps
interface fpio_pad_if #(parameter int W = 8);
  import fpio_pkg::*;
  logic      [W-1:0] val;
  fpio_drv_t         mode [W];
  logic      [W-1:0] pad;
  logic      [W-1:0] oe;
  modport core (output val, mode, input pad, oe);
  modport drv  (input val, mode, output pad, oe);
endinterface

interface fpio_irq_if;
  logic [2:0] lvl;
  logic [2:0] act;
  logic [2:0] rise;
  logic [2:0] en;
  logic       clr_we;
  logic [2:0] clr_data;
  logic [2:0] pend;
  logic [2:0] req;
  modport core (output lvl, act, rise, en, clr_we, clr_data, input pend, req);
  modport unit (input lvl, act, rise, en, clr_we, clr_data, output pend, req);
endinterface

// ### inc/fpio_pkg.sv
package fpio_pkg;
  // Register map
  localparam logic [7:0] ADDR_PA_DATA = 8'he0;
  localparam logic [7:0] ADDR_PB_DATA = 8'he1;
  localparam logic [7:0] ADDR_PC_DATA = 8'he2;
  localparam logic [7:0] ADDR_PD_DATA = 8'he3;
  localparam logic [7:0] ADDR_PA_HI   = 8'he4;
  localparam logic [7:0] ADDR_PA_LO   = 8'he5;
  localparam logic [7:0] ADDR_PB_CTL  = 8'he6;
  localparam logic [7:0] ADDR_PC_HI   = 8'he7;
  localparam logic [7:0] ADDR_PC_LO   = 8'he8;
  localparam logic [7:0] ADDR_PD_HI   = 8'he9;
  localparam logic [7:0] ADDR_PD_LO   = 8'hea;
  localparam logic [7:0] ADDR_PA_IRQ  = 8'heb;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // Widths and pin positions
  localparam int PW        = 8;
  localparam int PB_W      = 3;
  localparam int IRQ_N     = 3;
  localparam int FLD_W     = 2;
  localparam int HALF      = 4;
  localparam int PIN_CAP   = 4;
  localparam int PIN_SCL   = 1;
  localparam int PIN_SDA   = 0;
  localparam int PIN_CSYNC = 7;
  localparam int AN_CH     = 4;
  localparam int IRQ_PEND  = 4;

  // Field codes per port
  localparam logic [1:0] PA_LO_IN   = 2'h0;
  localparam logic [1:0] PA_LO_RISE = 2'h1;
  localparam logic [1:0] PA_LO_FALL = 2'h2;
  localparam logic [1:0] PA_LO_PP   = 2'h3;
  localparam logic [1:0] PA_HI_IN   = 2'h0;
  localparam logic [1:0] PA_HI_ALT  = 2'h1;
  localparam logic [1:0] PA_HI_PP   = 2'h2;
  localparam logic [1:0] PA_HI_PP2  = 2'h3;
  localparam logic [1:0] PB_IN      = 2'h0;
  localparam logic [1:0] PB_PP      = 2'h1;
  localparam logic [1:0] PB_OD      = 2'h2;
  localparam logic [1:0] PB_ALT     = 2'h3;
  localparam logic [1:0] PC_IN      = 2'h0;
  localparam logic [1:0] PC_PP      = 2'h1;
  localparam logic [1:0] PC_PWM_PP  = 2'h2;
  localparam logic [1:0] PC_PWM_OD  = 2'h3;
  localparam logic [1:0] PD_IN      = 2'h0;
  localparam logic [1:0] PD_ALT     = 2'h1;
  localparam logic [1:0] PD_PP      = 2'h2;
  localparam logic [1:0] PD_OD      = 2'h3;

  typedef enum logic [1:0] {FPIO_DRV_OFF, FPIO_DRV_PP, FPIO_DRV_OD} fpio_drv_t;

  // Two-bit field of pin i in a {high, low} control pair
  function automatic logic [1:0] fld(input logic [15:0] c, input int unsigned i);
    return c[i*FLD_W +: FLD_W];
  endfunction

  // Driven pins read their latch, others the sampled pin
  function automatic logic [7:0] rd_mux(input logic [7:0] drv, lat, pin);
    return (drv & lat) | (~drv & pin);
  endfunction
endpackage

// ### sim/fpio_board_pins.sv
`timescale 1ns/100ps
module fpio_board_pins #(parameter int W = 8)
(
  input  wire logic         clk_i,    // Bench clock
  input  wire logic [W-1:0] out_i,    // Block drive value
  input  wire logic [W-1:0] oe_i,     // Block drive enable
  input  wire logic [W-1:0] ext_i,    // Board drive value
  input  wire logic [W-1:0] ext_en_i, // Board drive enable
  input  wire logic [W-1:0] pull_i,   // Pull-up present
  output logic      [W-1:0] pin_o     // Resolved level
);
  logic [W-1:0] float_q = '0;
  // Floating lines wander so no stale level is trusted
  always_ff @(posedge clk_i) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_i[i];
      else if (pull_i[i]) pin_o[i] = 1'h1;
      else pin_o[i] = float_q[i];
    end
  end
endmodule

// ### sim/tb_four_port_pin_io_block.sv
`timescale 1ns/100ps
module tb_four_port_pin_io_block;
  import fpio_pkg::*;
  typedef struct {logic [7:0] a, d, e;} fpio_row_t;
  logic clk_sys_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic scl_drive_low_i = 0, sda_drive_low_i = 0, scl_in_o, sda_in_o, csync_in_o;
  logic ext_irq_zero_o, ext_irq_one_o, ext_irq_two_o, timer_a_capture_in_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, pwm_i = 0, reg_rdata_o, v;
  logic [7:0] pa_pin_i, pa_pin_o, pa_pin_oe_o, pc_pin_i, pc_pin_o, pc_pin_oe_o;
  logic [7:0] pd_pin_i, pd_pin_o, pd_pin_oe_o, pd_pullup_o;
  logic [7:0] ext_a = 0, en_a = 8'hff, ext_c = 0, en_c = 0;
  logic [7:0] pull_a = 8'h00, pull_c = 8'h00, ext_d = 8'h00, en_d = 8'h00;
  logic [2:0] ext_b = 3'h0, en_b = 3'h0, pull_b = 3'h7;
  logic [2:0] pb_pin_i, pb_pin_o, pb_pin_oe_o;
  logic [3:0] analog_in_channels_o;
  wire  [2:0] irq_v = {ext_irq_two_o, ext_irq_one_o, ext_irq_zero_o};
  int miscompares = 0, checks_done = 0;
  fpio_row_t rows [9] = '{'{8'he4, 8'h5a, 8'h5a}, '{8'he5, 8'ha5, 8'ha5}, '{8'he6, 8'hff, 8'h3f},
    '{8'he7, 8'h3c, 8'h3c}, '{8'he8, 8'hc3, 8'hc3}, '{8'he9, 8'h96, 8'h96}, '{8'hea, 8'h69, 8'h69},
    '{8'heb, 8'hff, 8'h07}, '{8'hec, 8'hff, 8'h00}};
  always #2 clk_sys_i = ~clk_sys_i;
  fpio_port_block DUT (.clk_sys_i, .rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .pa_pin_i, .pa_pin_o, .pa_pin_oe_o, .pb_pin_i, .pb_pin_o, .pb_pin_oe_o, .pc_pin_i,
    .pc_pin_o, .pc_pin_oe_o, .pd_pin_i, .pd_pin_o, .pd_pin_oe_o, .pd_pullup_o, .analog_in_channels_o,
    .ext_irq_zero_o, .ext_irq_one_o, .ext_irq_two_o, .timer_a_capture_in_o, .scl_drive_low_i,
    .sda_drive_low_i, .scl_in_o, .sda_in_o, .pwm_i, .csync_in_o);
  fpio_board_pins PA (.clk_i(clk_sys_i), .out_i(pa_pin_o), .oe_i(pa_pin_oe_o), .ext_i(ext_a),
    .ext_en_i(en_a), .pull_i(pull_a), .pin_o(pa_pin_i));
  fpio_board_pins #(.W(PB_W)) PB (.clk_i(clk_sys_i), .out_i(pb_pin_o), .oe_i(pb_pin_oe_o), .ext_i(ext_b),
    .ext_en_i(en_b), .pull_i(pull_b), .pin_o(pb_pin_i));
  fpio_board_pins PC (.clk_i(clk_sys_i), .out_i(pc_pin_o), .oe_i(pc_pin_oe_o), .ext_i(ext_c),
    .ext_en_i(en_c), .pull_i(pull_c), .pin_o(pc_pin_i));
  fpio_board_pins PD (.clk_i(clk_sys_i), .out_i(pd_pin_o), .oe_i(pd_pin_oe_o), .ext_i(ext_d),
    .ext_en_i(en_d), .pull_i(pd_pullup_o), .pin_o(pd_pin_i));
  task automatic chk(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_sys_i);
    reg_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1;
    @(negedge clk_sys_i);
    reg_rd_i = 0;
    v = reg_rdata_o;
  endtask
  task automatic do_reset;
    @(negedge clk_sys_i);
    rst_i = 1;
    cyc(4);
    rst_i = 0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    wrap_up;
  end
  initial begin
    do_reset;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(v, rows[i].e, "regmap");
    end
    do_reset;
    rd(8'he4);
    chk(v, 8'h00, "reset ctrl");
    chk({pa_pin_oe_o}, 8'h00, "reset oe");
    chk({7'h0, scl_in_o}, 8'h01, "reset scl");
    ce_i = 0;
    wr(8'he4, 8'hff);
    ce_i = 1;
    rd(8'he4);
    chk(v, 8'h00, "frozen write");
    wr(8'he4, 8'hae);
    wr(8'he5, 8'hff);
    wr(8'he0, 8'h5c);
    cyc(2);
    chk(pa_pin_oe_o, 8'hff, "pa oe");
    chk(pa_pin_o, 8'h5c, "pa out");
    wr(8'he4, 8'h00);
    wr(8'he5, 8'h00);
    ext_a = 8'h3c;
    cyc(2);
    rd(8'he0);
    chk(v, 8'h3c, "pa in");
    wr(8'he4, 8'h01);
    ext_a = 8'h10;
    cyc(3);
    chk({7'h0, timer_a_capture_in_o}, 8'h01, "capture");
    ext_a = 8'h00;
    for (int i = 0; i < 3; i++) begin
      wr(8'he5, 8'h01 << (2 * i));
      wr(8'heb, 8'h01 << i);
      ext_a[i] = 1;
      cyc(3);
      chk({5'h0, irq_v}, 8'h01 << i, "irq rise");
      rd(8'heb);
      chk(v, 8'h11 << i, "irq pend");
      wr(8'heb, 8'h01 << i);
      chk({5'h0, irq_v}, 8'h00, "irq clr");
    end
    wr(8'he5, 8'h08);
    wr(8'heb, 8'h02);
    ext_a = 8'h00;
    cyc(3);
    chk({5'h0, irq_v}, 8'h02, "irq fall");
    wr(8'he6, 8'h2a);
    wr(8'he1, 8'h00);
    cyc(2);
    chk({2'h0, pb_pin_oe_o, pb_pin_o}, 8'h38, "pb od");
    wr(8'he6, 8'h15);
    wr(8'he1, 8'h05);
    cyc(2);
    chk({2'h0, pb_pin_oe_o, pb_pin_o}, 8'h3d, "pb pp");
    wr(8'he6, 8'h0f);
    scl_drive_low_i = 1;
    cyc(3);
    chk({6'h0, scl_in_o, sda_in_o}, 8'h01, "bus");
    wr(8'he6, 8'h00);
    {ext_b, en_b} = 6'h2f;
    cyc(2);
    rd(8'he1);
    chk(v, 8'h05, "pb in");
    {ext_c, en_c} = 16'ha5ff;
    cyc(2);
    rd(8'he2);
    chk(v, 8'ha5, "pc in");
    wr(8'he8, 8'haa);
    pwm_i = 8'h05;
    {ext_c, en_c} = 16'h8080;
    cyc(3);
    chk({pc_pin_oe_o[3:0], pc_pin_o[3:0]}, 8'hf5, "pwm");
    chk({7'h0, csync_in_o}, 8'h01, "csync");
    wr(8'he2, 8'h90);
    wr(8'he7, 8'h55);
    cyc(2);
    chk({pc_pin_oe_o[7:4], pc_pin_o[7:4]}, 8'hf9, "pc pp");
    chk({7'h0, csync_in_o}, 8'h00, "csync off");
    wr(8'hea, 8'h55);
    wr(8'he9, 8'h55);
    cyc(2);
    chk({analog_in_channels_o, 4'h0}, 8'hf0, "analog");
    chk(pd_pullup_o, 8'hf0, "pullup");
    rd(8'he3);
    chk(v, 8'hf0, "pd in");
    wr(8'hea, 8'haa);
    wr(8'he3, 8'h5a);
    wr(8'he9, 8'hff);
    cyc(2);
    chk(pd_pin_oe_o, 8'haf, "pd oe");
    chk(pd_pin_o, 8'h0a, "pd out");
    wrap_up;
  end
endmodule

// ### verilog/fpio_irq_unit.sv
`timescale 1ns/100ps
module fpio_irq_unit
  import fpio_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Sync reset
  input wire logic ce_i,      // Clock enable
  fpio_irq_if.unit irq        // Edge config in, pending out
);
  logic [2:0] prev_d, prev_q, pend_d, pend_q, req_d, req_q, hit;
  logic       arm_q;

  always_comb begin
    prev_d = irq.lvl;
    // No edge before the first sample is held
    hit = {IRQ_N{arm_q}} & irq.act &
          ((irq.rise & irq.lvl & ~prev_q) | (~irq.rise & ~irq.lvl & prev_q));
    pend_d = pend_q;
    if (irq.clr_we)
      pend_d = pend_q & irq.clr_data;
    pend_d = pend_d | hit;
    req_d  = pend_d & irq.en & irq.act;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prev_q <= '0;
      pend_q <= '0;
      req_q  <= '0;
      arm_q  <= 1'b0;
    end else if (ce_i) begin
      prev_q <= prev_d;
      pend_q <= pend_d;
      req_q  <= req_d;
      arm_q  <= 1'b1;
    end
  end

  assign irq.pend = pend_q;
  assign irq.req  = req_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_rise_sets_pend: assert property (
    (ce_i && arm_q && irq.act[0] && irq.rise[0] && irq.lvl[0] && !prev_q[0]) |=> pend_q[0])
    else $error("rising edge did not set pending");
  a_fall_sets_pend: assert property (
    (ce_i && arm_q && irq.act[1] && !irq.rise[1] && !irq.lvl[1] && prev_q[1]) |=> pend_q[1])
    else $error("falling edge did not set pending");
  a_irq_gated_off: assert property (
    (ce_i && !irq.act[2]) |=> !req_q[2])
    else $error("request raised on disabled pin");
  a_pend_sticky: assert property (
    (ce_i && pend_q[2] && !irq.clr_we) |=> pend_q[2])
    else $error("pending lost without clear");
endmodule

// ### verilog/fpio_pad_drv.sv
`timescale 1ns/100ps
module fpio_pad_drv
  import fpio_pkg::*;
#(parameter int W = 8)
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Sync reset
  input wire logic ce_i,      // Clock enable
  fpio_pad_if.drv  pad        // Pin modes in, drive out
);
  logic [W-1:0] out_d, out_q, oe_d, oe_q;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = 1'b0;
      oe_d[i]  = 1'b0;
      unique case (pad.mode[i])
        FPIO_DRV_OFF: ;
        FPIO_DRV_PP: begin
          out_d[i] = pad.val[i];
          oe_d[i]  = 1'b1;
        end
        // Open drain only ever pulls low
        FPIO_DRV_OD: oe_d[i] = ~pad.val[i];
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_q <= '0;
      oe_q  <= '0;
    end else if (ce_i) begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pad.pad = out_q;
  assign pad.oe  = oe_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_od_low_only: assert property (
    (ce_i && pad.mode[0] == FPIO_DRV_OD) |=> (!out_q[0] && oe_q[0] == !$past(pad.val[0])))
    else $error("open drain pin drove high or missed low");
endmodule

// ### verilog/fpio_port_block.sv
`timescale 1ns/100ps
module fpio_port_block
  import fpio_pkg::*;
(
  input  wire logic            clk_sys_i,            // 250 MHz system clock
  input  wire logic            rst_i,                // Sync reset, active high
  input  wire logic            ce_i,                 // Clock enable, freezes state
  input  wire logic [7:0]      reg_addr_i,           // Register address
  input  wire logic            reg_wr_i,             // Write strobe
  input  wire logic            reg_rd_i,             // Read strobe
  input  wire logic [7:0]      reg_wdata_i,          // Write data
  output logic      [7:0]      reg_rdata_o,          // Read data, next cycle
  input  wire logic [PW-1:0]   pa_pin_i,             // Port A pin levels
  output logic      [PW-1:0]   pa_pin_o,             // Port A drive value
  output logic      [PW-1:0]   pa_pin_oe_o,          // Port A drive enable
  input  wire logic [PB_W-1:0] pb_pin_i,             // Port B pin levels
  output logic      [PB_W-1:0] pb_pin_o,             // Port B drive value
  output logic      [PB_W-1:0] pb_pin_oe_o,          // Port B drive enable
  input  wire logic [PW-1:0]   pc_pin_i,             // Port C pin levels
  output logic      [PW-1:0]   pc_pin_o,             // Port C drive value
  output logic      [PW-1:0]   pc_pin_oe_o,          // Port C drive enable
  input  wire logic [PW-1:0]   pd_pin_i,             // Port D pin levels
  output logic      [PW-1:0]   pd_pin_o,             // Port D drive value
  output logic      [PW-1:0]   pd_pin_oe_o,          // Port D drive enable
  output logic      [PW-1:0]   pd_pullup_o,          // Port D pull-up enable
  output logic      [AN_CH-1:0] analog_in_channels_o, // Analog input select
  output logic                 ext_irq_zero_o,       // Edge interrupt 0
  output logic                 ext_irq_one_o,        // Edge interrupt 1
  output logic                 ext_irq_two_o,        // Edge interrupt 2
  output logic                 timer_a_capture_in_o, // Timer capture input
  input  wire logic            scl_drive_low_i,      // Two-wire clock pull
  input  wire logic            sda_drive_low_i,      // Two-wire data pull
  output logic                 scl_in_o,             // Two-wire clock seen
  output logic                 sda_in_o,             // Two-wire data seen
  input  wire logic [PW-1:0]   pwm_i,                // PWM channel levels
  output logic                 csync_in_o            // Composite sync seen
);
  // Register group
  logic [PW-1:0]    pa_data_d, pa_data_q, pc_data_d, pc_data_q, pd_data_d, pd_data_q;
  logic [PB_W-1:0]  pb_data_d, pb_data_q;
  logic [7:0]       pa_hi_d, pa_hi_q, pa_lo_d, pa_lo_q, pc_hi_d, pc_hi_q;
  logic [7:0]       pc_lo_d, pc_lo_q, pd_hi_d, pd_hi_q, pd_lo_d, pd_lo_q;
  logic [2*PB_W-1:0] pb_ctl_d, pb_ctl_q;
  logic [IRQ_N-1:0] irq_en_d, irq_en_q;
  logic [7:0]       rdata_d, rdata_q;
  // Pin group
  logic [PW-1:0]    pa_pin_q, pc_pin_q, pd_pin_q;
  logic [PB_W-1:0]  pb_pin_q;
  logic             cap_d, cap_q, scl_d, scl_q, sda_d, sda_q, cs_d, cs_q;
  logic [AN_CH-1:0] an_d, an_q;
  logic [PW-1:0]    pull_d, pull_q;
  // Pin function decode
  logic [15:0]      pa_ctl, pc_ctl, pd_ctl;
  logic [PW-1:0]    pa_drv, pc_drv, pd_drv, pd_an;
  logic [7:0]       pb_drv;
  logic [1:0]       f;

  fpio_pad_if #(.W(PW))   pa_if ();
  fpio_pad_if #(.W(PB_W)) pb_if ();
  fpio_pad_if #(.W(PW))   pc_if ();
  fpio_pad_if #(.W(PW))   pd_if ();
  fpio_irq_if             irq_if ();

  assign pa_ctl = {pa_hi_q, pa_lo_q};
  assign pc_ctl = {pc_hi_q, pc_lo_q};
  assign pd_ctl = {pd_hi_q, pd_lo_q};

  // Each pin's field picks its driver and value
  always_comb begin
    pa_drv = '0;
    pc_drv = '0;
    pd_drv = '0;
    pd_an  = '0;
    pb_drv = '0;
    pull_d = '0;
    an_d   = '0;
    f      = 2'h0;
    for (int i = 0; i < PW; i++) begin
      // Port A: low half push-pull, high half push-pull on either upper code
      f = fld(pa_ctl, i);
      pa_if.val[i]  = pa_data_q[i];
      pa_if.mode[i] = FPIO_DRV_OFF;
      if (i < HALF ? (f == PA_LO_PP) : (f == PA_HI_PP || f == PA_HI_PP2)) begin
        pa_if.mode[i] = FPIO_DRV_PP;
        pa_drv[i]     = 1'b1;
      end
      // Port C: plain source push-pull, PWM source push-pull or open drain
      f = fld(pc_ctl, i);
      pc_if.val[i]  = (f == PC_PP) ? pc_data_q[i] : pwm_i[i];
      pc_if.mode[i] = (f == PC_IN) ? FPIO_DRV_OFF : (f == PC_PWM_OD) ? FPIO_DRV_OD : FPIO_DRV_PP;
      pc_drv[i]     = (f == PC_PP);
      // Port D: alt code is analog on low pins, pull-up on high pins
      f = fld(pd_ctl, i);
      pd_if.val[i]  = pd_data_q[i];
      pd_if.mode[i] = (f == PD_PP) ? FPIO_DRV_PP : (f == PD_OD) ? FPIO_DRV_OD : FPIO_DRV_OFF;
      pd_drv[i]     = (f == PD_PP || f == PD_OD);
      if (f == PD_ALT) begin
        if (i < AN_CH) begin
          pd_an[i]                       = 1'b1;
          an_d[i[$clog2(AN_CH)-1:0]]     = 1'b1;
        end else begin
          pull_d[i] = 1'b1;
        end
      end
    end
    for (int i = 0; i < PB_W; i++) begin
      f = pb_ctl_q[i*FLD_W +: FLD_W];
      pb_if.val[i]  = pb_data_q[i];
      pb_if.mode[i] = (f == PB_PP) ? FPIO_DRV_PP : (f == PB_OD) ? FPIO_DRV_OD : FPIO_DRV_OFF;
      pb_drv[i]     = (f == PB_PP || f == PB_OD);
      if (f == PB_ALT && (i == PIN_SCL || i == PIN_SDA)) begin
        // Bus lines are released or pulled low by the two-wire master
        pb_if.mode[i] = FPIO_DRV_OD;
        pb_if.val[i]  = (i == PIN_SCL) ? ~scl_drive_low_i : ~sda_drive_low_i;
      end
    end
    cap_d = (fld(pa_ctl, PIN_CAP) == PA_HI_ALT) & pa_pin_q[PIN_CAP];
    scl_d = (pb_ctl_q[PIN_SCL*FLD_W +: FLD_W] == PB_ALT) ? pb_pin_q[PIN_SCL] : 1'b1;
    sda_d = (pb_ctl_q[PIN_SDA*FLD_W +: FLD_W] == PB_ALT) ? pb_pin_q[PIN_SDA] : 1'b1;
    cs_d  = (fld(pc_ctl, PIN_CSYNC) == PC_IN) & pc_pin_q[PIN_CSYNC];
  end

  // Edge interrupt hookup
  always_comb begin
    for (int i = 0; i < IRQ_N; i++) begin
      irq_if.act[i]  = (fld(pa_ctl, i) == PA_LO_RISE) || (fld(pa_ctl, i) == PA_LO_FALL);
      irq_if.rise[i] = (fld(pa_ctl, i) == PA_LO_RISE);
    end
    irq_if.lvl      = pa_pin_q[IRQ_N-1:0];
    irq_if.en       = irq_en_q;
    irq_if.clr_we   = reg_wr_i && (reg_addr_i == ADDR_PA_IRQ);
    irq_if.clr_data = reg_wdata_i[IRQ_PEND +: IRQ_N];
  end

  // Register writes and reads; no other access path exists
  always_comb begin
    pa_data_d = pa_data_q;
    pb_data_d = pb_data_q;
    pc_data_d = pc_data_q;
    pd_data_d = pd_data_q;
    pa_hi_d   = pa_hi_q;
    pa_lo_d   = pa_lo_q;
    pb_ctl_d  = pb_ctl_q;
    pc_hi_d   = pc_hi_q;
    pc_lo_d   = pc_lo_q;
    pd_hi_d   = pd_hi_q;
    pd_lo_d   = pd_lo_q;
    irq_en_d  = irq_en_q;
    rdata_d   = rdata_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_PA_DATA: pa_data_d = reg_wdata_i;
        ADDR_PB_DATA: pb_data_d = reg_wdata_i[PB_W-1:0];
        ADDR_PC_DATA: pc_data_d = reg_wdata_i;
        ADDR_PD_DATA: pd_data_d = reg_wdata_i;
        ADDR_PA_HI:   pa_hi_d   = reg_wdata_i;
        ADDR_PA_LO:   pa_lo_d   = reg_wdata_i;
        ADDR_PB_CTL:  pb_ctl_d  = reg_wdata_i[2*PB_W-1:0];
        ADDR_PC_HI:   pc_hi_d   = reg_wdata_i;
        ADDR_PC_LO:   pc_lo_d   = reg_wdata_i;
        ADDR_PD_HI:   pd_hi_d   = reg_wdata_i;
        ADDR_PD_LO:   pd_lo_d   = reg_wdata_i;
        ADDR_PA_IRQ:  irq_en_d  = reg_wdata_i[IRQ_N-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_PA_DATA: rdata_d = rd_mux(pa_drv, pa_data_q, pa_pin_q);
        ADDR_PB_DATA: rdata_d = rd_mux(pb_drv, 8'(pb_data_q), 8'(pb_pin_q));
        ADDR_PC_DATA: rdata_d = rd_mux(pc_drv, pc_data_q, pc_pin_q);
        ADDR_PD_DATA: rdata_d = rd_mux(pd_drv, pd_data_q, pd_pin_q & ~pd_an);
        ADDR_PA_HI:   rdata_d = pa_hi_q;
        ADDR_PA_LO:   rdata_d = pa_lo_q;
        ADDR_PB_CTL:  rdata_d = 8'(pb_ctl_q);
        ADDR_PC_HI:   rdata_d = pc_hi_q;
        ADDR_PC_LO:   rdata_d = pc_lo_q;
        ADDR_PD_HI:   rdata_d = pd_hi_q;
        ADDR_PD_LO:   rdata_d = pd_lo_q;
        ADDR_PA_IRQ:  rdata_d = 8'({irq_if.pend, 1'b0, irq_en_q} << 0);
        default:      rdata_d = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pa_data_q <= RST_BYTE;
      pb_data_q <= '0;
      pc_data_q <= RST_BYTE;
      pd_data_q <= RST_BYTE;
      pa_hi_q   <= RST_BYTE;
      pa_lo_q   <= RST_BYTE;
      pb_ctl_q  <= '0;
      pc_hi_q   <= RST_BYTE;
      pc_lo_q   <= RST_BYTE;
      pd_hi_q   <= RST_BYTE;
      pd_lo_q   <= RST_BYTE;
      irq_en_q  <= '0;
      rdata_q   <= RST_BYTE;
    end else if (ce_i) begin
      pa_data_q <= pa_data_d;
      pb_data_q <= pb_data_d;
      pc_data_q <= pc_data_d;
      pd_data_q <= pd_data_d;
      pa_hi_q   <= pa_hi_d;
      pa_lo_q   <= pa_lo_d;
      pb_ctl_q  <= pb_ctl_d;
      pc_hi_q   <= pc_hi_d;
      pc_lo_q   <= pc_lo_d;
      pd_hi_q   <= pd_hi_d;
      pd_lo_q   <= pd_lo_d;
      irq_en_q  <= irq_en_d;
      rdata_q   <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pa_pin_q <= '0;
      pb_pin_q <= '0;
      pc_pin_q <= '0;
      pd_pin_q <= '0;
      cap_q    <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      cs_q     <= 1'b0;
      an_q     <= '0;
      pull_q   <= '0;
    end else if (ce_i) begin
      pa_pin_q <= pa_pin_i;
      pb_pin_q <= pb_pin_i;
      pc_pin_q <= pc_pin_i;
      pd_pin_q <= pd_pin_i;
      cap_q    <= cap_d;
      scl_q    <= scl_d;
      sda_q    <= sda_d;
      cs_q     <= cs_d;
      an_q     <= an_d;
      pull_q   <= pull_d;
    end
  end

  fpio_pad_drv #(.W(PW))   u_pa (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .pad(pa_if.drv));
  fpio_pad_drv #(.W(PB_W)) u_pb (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .pad(pb_if.drv));
  fpio_pad_drv #(.W(PW))   u_pc (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .pad(pc_if.drv));
  fpio_pad_drv #(.W(PW))   u_pd (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .pad(pd_if.drv));
  fpio_irq_unit            u_irq (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .irq(irq_if.unit));

  assign pa_pin_o             = pa_if.pad;
  assign pa_pin_oe_o          = pa_if.oe;
  assign pb_pin_o             = pb_if.pad;
  assign pb_pin_oe_o          = pb_if.oe;
  assign pc_pin_o             = pc_if.pad;
  assign pc_pin_oe_o          = pc_if.oe;
  assign pd_pin_o             = pd_if.pad;
  assign pd_pin_oe_o          = pd_if.oe;
  assign pd_pullup_o          = pull_q;
  assign analog_in_channels_o = an_q;
  assign ext_irq_zero_o       = irq_if.req[0];
  assign ext_irq_one_o        = irq_if.req[1];
  assign ext_irq_two_o        = irq_if.req[2];
  assign timer_a_capture_in_o = cap_q;
  assign scl_in_o             = scl_q;
  assign sda_in_o             = sda_q;
  assign csync_in_o           = cs_q;
  assign reg_rdata_o          = rdata_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_data_write: assert property (
    (ce_i && reg_wr_i && reg_addr_i == ADDR_PA_DATA) |=> (pa_data_q == $past(reg_wdata_i)))
    else $error("port A data write not stored");
  a_read_input: assert property (
    (ce_i && reg_rd_i && reg_addr_i == ADDR_PC_DATA && pc_hi_q == RST_BYTE && pc_lo_q == RST_BYTE)
      |=> (reg_rdata_o == $past(pc_pin_q)))
    else $error("input pin read wrong level");
  a_low_pushpull: assert property (
    (ce_i && fld(pa_ctl, 0) == PA_LO_PP) |=> (pa_pin_oe_o[0] && pa_pin_o[0] == $past(pa_data_q[0])))
    else $error("low pin not push-pull");
  a_capture_sel: assert property (
    (ce_i && fld(pa_ctl, PIN_CAP) == PA_HI_ALT) |=> (timer_a_capture_in_o == $past(pa_pin_q[PIN_CAP])))
    else $error("capture input not routed");
  a_pwm_od_drive: assert property (
    (ce_i && fld(pc_ctl, 0) == PC_PWM_OD) |=> (pc_pin_oe_o[0] == !$past(pwm_i[0]) && !pc_pin_o[0]))
    else $error("PWM open drain drive wrong");
  a_analog_sel: assert property (
    (ce_i && fld(pd_ctl, 0) == PD_ALT) |=> (analog_in_channels_o[0] && !pd_pin_oe_o[0]))
    else $error("analog channel not selected");
  a_scl_pull: assert property (
    (ce_i && pb_ctl_q[PIN_SCL*FLD_W +: FLD_W] == PB_ALT && scl_drive_low_i)
      |=> (pb_pin_oe_o[PIN_SCL] && !pb_pin_o[PIN_SCL]))
    else $error("bus clock not pulled low");
endmodule
